/* File: inc/ust_pkg.sv */
// shared constants and types for the uart serial trigger
package ust_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int BAUD_DEF = 115_200;
   localparam logic [15:0] BIT_CYC_DEF = 16'(CLK_HZ / BAUD_DEF);
   localparam logic [23:0] IDLE_CYC_DEF = 24'h000d80;

   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_BAUD = 8'h04;
   localparam logic [7:0] A_IDLE = 8'h08;
   localparam logic [7:0] A_PCFG = 8'h0c;
   localparam logic [7:0] A_PVAL = 8'h10;
   localparam logic [7:0] A_PMASK = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_RTIME = 8'h1c;
   localparam logic [7:0] A_RDATA = 8'h20;
   localparam logic [7:0] A_RSTATE = 8'h24;

   // field positions
   localparam int F_MODE = 0;
   localparam int F_SRC = 3;
   localparam int F_PAR = 4;
   localparam int F_STOP = 6;
   localparam int F_DSIZE = 8;
   localparam int F_CNT = 16;

   // reset values and limits
   localparam logic [3:0] DSIZE_RST = 4'h8;
   localparam logic [3:0] DSIZE_MIN = 4'h5;
   localparam logic [3:0] DSIZE_MAX = 4'h9;
   localparam logic [2:0] CNT_MAX = 3'h4;

   // trigger modes
   localparam logic [2:0] M_START = 3'h0;
   localparam logic [2:0] M_FSTART = 3'h1;
   localparam logic [2:0] M_FERR = 3'h2;
   localparam logic [2:0] M_SYM = 3'h3;
   localparam logic [2:0] M_BRK = 3'h4;
   localparam logic [2:0] M_PERR = 3'h5;
   localparam logic [2:0] M_PAT = 3'h6;
   localparam logic [2:0] M_ANY = 3'h7;

   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic [1:0] STOP_15 = 2'h1;
   localparam logic [1:0] STOP_2 = 2'h2;

   typedef enum logic [2:0] {
      RX_IDLE = 3'h0,
      RX_START = 3'h1,
      RX_DATA = 3'h3,
      RX_PAR = 3'h2,
      RX_STOP = 3'h6,
      RX_HOLD = 3'h7
   } ust_rx_state_t;
endpackage

/* File: inc/ust_sym_if.sv */
// symbol events from the line receiver to the trigger core
interface ust_sym_if;
   logic st_edge;
   logic idle_ok;
   logic done;
   logic [8:0] data;
   logic ferr;
   logic perr;
   logic brk;
   modport rx (output st_edge, idle_ok, done, data, ferr, perr, brk);
   modport core (input st_edge, idle_ok, done, data, ferr, perr, brk);
endinterface

/* File: rtl/ust_symcmp.sv */
// one pattern symbol compared with per-bit don't-care
module ust_symcmp #(
   parameter int W = 8
) (
   input wire logic [W-1:0] val,
   input wire logic [W-1:0] care,
   input wire logic [W-1:0] data,
   output logic hit
);
   assign hit = ((val ^ data) & care) == '0; // RULE15
endmodule

/* File: rtl/ust_rx.sv */
// serial line receiver: start, data, parity and stop sampling
module ust_rx #(
   parameter int CW = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic line,
   input wire logic [CW-1:0] bit_cyc,
   input wire logic [3:0] dsize,
   input wire logic [1:0] par,
   input wire logic [1:0] stop,
   input wire logic [23:0] idle_cyc,
   ust_sym_if.rx s
);
   ust_pkg::ust_rx_state_t st_reg, st_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [3:0] bit_reg;
   logic [8:0] sh_reg;
   logic pb_reg;
   logic [23:0] idle_reg;

   wire tick = (cnt_reg == '0);
   wire [CW-1:0] half = bit_cyc >> 1;
   wire [CW-1:0] full = bit_cyc - CW'(1);
   wire [CW-1:0] extra = (stop == ust_pkg::STOP_2) ? bit_cyc : (stop == ust_pkg::STOP_15) ? half : '0; // RULE21
   wire [8:0] dat = sh_reg >> (4'd9 - dsize);
   wire last_bit = (bit_reg == dsize - 4'd1);
   wire par_exp = (^dat) ^ (par == ust_pkg::PAR_ODD); // RULE20
   wire done = (st_reg == ust_pkg::RX_STOP) && tick;
   wire ferr = done && !line; // RULE5
   wire edge_lo = (st_reg == ust_pkg::RX_IDLE) && !line; // RULE2

   assign s.st_edge = edge_lo;
   assign s.idle_ok = idle_reg >= idle_cyc;
   assign s.done = done;
   assign s.data = dat;
   assign s.ferr = ferr;
   assign s.perr = done && (par != ust_pkg::PAR_NONE) && (pb_reg != par_exp); // RULE8
   // line held low through a whole word
   assign s.brk = ferr && (dat == '0) && ((par == ust_pkg::PAR_NONE) || !pb_reg); // RULE7

   always_comb begin
      st_next = st_reg;
      cnt_next = tick ? full : cnt_reg - CW'(1);
      case (st_reg)
         ust_pkg::RX_IDLE: begin
            // one short: the line register and the start detect already cost cycles
            cnt_next = half - CW'(1);
            if (!line) st_next = ust_pkg::RX_START;
         end
         ust_pkg::RX_START: begin
            if (tick) st_next = line ? ust_pkg::RX_IDLE : ust_pkg::RX_DATA;
         end
         ust_pkg::RX_DATA: begin
            if (tick && last_bit) st_next = (par == ust_pkg::PAR_NONE) ? ust_pkg::RX_STOP : ust_pkg::RX_PAR;
         end
         ust_pkg::RX_PAR: begin
            if (tick) st_next = ust_pkg::RX_STOP;
         end
         ust_pkg::RX_STOP: begin
            if (tick) begin
               st_next = ust_pkg::RX_HOLD;
               cnt_next = extra;
            end
         end
         ust_pkg::RX_HOLD: begin
            // no new start until the line is back high
            if (tick) cnt_next = '0;
            if (tick && line) st_next = ust_pkg::RX_IDLE;
         end
         default: st_next = ust_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg <= ust_pkg::RX_IDLE;
         cnt_reg <= '0;
         bit_reg <= '0;
         sh_reg <= '0;
         pb_reg <= 1'b0;
         idle_reg <= '1;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         if (st_reg == ust_pkg::RX_START) bit_reg <= '0;
         if (st_reg == ust_pkg::RX_DATA && tick) begin
            sh_reg <= {line, sh_reg[8:1]};
            bit_reg <= bit_reg + 4'd1;
         end
         if (st_reg == ust_pkg::RX_PAR && tick) pb_reg <= line;
         if (st_reg == ust_pkg::RX_HOLD) idle_reg <= '0; // RULE22
         else if (st_reg == ust_pkg::RX_IDLE && line && idle_reg != '1) idle_reg <= idle_reg + 24'd1;
      end
   end
endmodule

/* File: rtl/ust_trigger.sv */
// apb-controlled uart serial trigger with per-frame decode record
// How it works
// [RULE1] trigger input is either the transmit or the receive line
// [RULE2] start-bit mode fires on first low after a stop bit
// [RULE3] frame-start mode fires on first start bit after enough idle
// [RULE4] frame-error mode fires on every symbol with a framing error
// [RULE5] framing error means the first stop-bit sample is low
// [RULE6] symbol mode fires on the symbol at the offset position
// [RULE7] break mode fires when the line stays low past a word
// [RULE8] parity-error mode fires on a parity mismatch
// [RULE9] pattern mode fires when the symbol sequence after the offset matches
// [RULE10] any-symbol mode fires when any symbol matches the first pattern symbol
// [RULE11] offset symbols are skipped; the next one is compared first
// [RULE12] offset runs from 0 to 4095 symbols
// [RULE13] pattern symbol count runs from 1 to 4
// [RULE14] defining pattern bits beyond the count raises the count
// [RULE15] pattern bits are 0, 1 or don't-care
// [RULE16] pattern compare matters only in pattern and any-symbol modes
// [RULE17] each frame records start time versus trigger, data and error state
// [RULE18] symbol position restarts at zero at each frame start
// [RULE19] the sender's start bit is low, stop bits and idle high
// [RULE20] even parity bit is one for odd ones count, odd the reverse
// [RULE21] words carry 5 to 9 data bits and 1, 1.5 or 2 stops
// [RULE22] idle is measured from last stop bit to next start bit
module ust_trigger #(
   parameter int OFF_W = 12
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic line_tx,
   input wire logic line_rx,
   output logic trig_out
);
   logic [2:0] mode_reg;
   logic src_tx_reg;
   logic [1:0] par_reg;
   logic [1:0] stop_reg;
   logic [3:0] dsize_reg;
   logic [15:0] bit_cyc_reg;
   logic [23:0] idle_cyc_reg;
   logic [OFF_W-1:0] off_reg;
   logic [1:0] cnt_m1_reg;
   logic [31:0] pval_reg;
   logic [31:0] pmask_reg;
   logic line_reg;
   logic [OFF_W-1:0] pos_reg;
   logic seq_reg;
   logic [15:0] trig_cnt_reg;
   logic [31:0] ts_reg;
   logic [31:0] fs_time_reg;
   logic [31:0] trig_time_reg;
   logic [8:0] rdata_reg;
   logic [OFF_W-1:0] words_reg;
   logic [2:0] rstate_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic trig_reg;
   logic [3:0] cmp;

   ust_sym_if sym ();

   ust_rx #(.CW(16)) u_rx (
      .clk_sys(clk_sys),
      .rst(rst),
      .line(line_reg),
      .bit_cyc(bit_cyc_reg),
      .dsize(dsize_reg),
      .par(par_reg),
      .stop(stop_reg),
      .idle_cyc(idle_cyc_reg),
      .s(sym.rx)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // register decode
   wire setup = psel && !penable;
   wire wr = psel && penable && pready_reg && pwrite;
   wire hit_ctrl = paddr == ust_pkg::A_CTRL;
   wire hit_baud = paddr == ust_pkg::A_BAUD;
   wire hit_idle = paddr == ust_pkg::A_IDLE;
   wire hit_pcfg = paddr == ust_pkg::A_PCFG;
   wire hit_pval = paddr == ust_pkg::A_PVAL;
   wire hit_pmask = paddr == ust_pkg::A_PMASK;
   wire hit_stat = paddr == ust_pkg::A_STAT;
   wire hit_rtime = paddr == ust_pkg::A_RTIME;
   wire hit_rdata = paddr == ust_pkg::A_RDATA;
   wire hit_rstate = paddr == ust_pkg::A_RSTATE;
   wire addr_ok = |{hit_ctrl, hit_baud, hit_idle, hit_pcfg, hit_pval, hit_pmask, hit_stat, hit_rtime,
      hit_rdata, hit_rstate};

   wire [31:0] rd_mux =
      hit_ctrl ? {20'h0, dsize_reg, stop_reg, par_reg, src_tx_reg, mode_reg} :
      hit_baud ? {16'h0, bit_cyc_reg} :
      hit_idle ? {8'h0, idle_cyc_reg} :
      hit_pcfg ? {13'h0, 3'(cnt_m1_reg) + 3'd1, 4'h0, 12'(off_reg)} :
      hit_pval ? pval_reg :
      hit_pmask ? pmask_reg :
      hit_stat ? {16'(pos_reg), trig_cnt_reg} :
      hit_rtime ? fs_time_reg - trig_time_reg :
      hit_rdata ? {16'(words_reg), 7'h0, rdata_reg} :
      hit_rstate ? {29'h0, rstate_reg} : 32'h0;

   wire [3:0] dsize_w = pwdata[ust_pkg::F_DSIZE +: 4];
   wire [3:0] dsize_fix = (dsize_w < ust_pkg::DSIZE_MIN) ? ust_pkg::DSIZE_MIN :
      (dsize_w > ust_pkg::DSIZE_MAX) ? ust_pkg::DSIZE_MAX : dsize_w; // RULE21
   wire [2:0] cnt_w = pwdata[ust_pkg::F_CNT +: 3];
   wire [1:0] cnt_fix = (cnt_w == 3'h0) ? 2'h0 :
      (cnt_w > ust_pkg::CNT_MAX) ? 2'h3 : 2'(cnt_w - 3'h1); // RULE13
   wire [31:0] mask_new = (wr && hit_pmask) ? pwdata : pmask_reg;
   wire [1:0] hi_sym = (|mask_new[31:24]) ? 2'h3 : (|mask_new[23:16]) ? 2'h2 :
      (|mask_new[15:8]) ? 2'h1 : 2'h0;
   wire pat_wr = wr && (hit_pval || hit_pmask);
   wire [OFF_W-1:0] off_w = pwdata[OFF_W-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // trigger conditions
   wire [OFF_W-1:0] k = pos_reg - off_reg;
   wire in_win = (pos_reg >= off_reg) && (k <= OFF_W'(cnt_m1_reg)); // RULE11
   wire sel_hit = cmp[k[1:0]];
   wire chain_ok = sel_hit && ((k == '0) || seq_reg);
   wire fs = sym.st_edge && sym.idle_ok; // RULE3
   wire f_pat = sym.done && in_win && chain_ok && (k[1:0] == cnt_m1_reg); // RULE9
   wire f_any = sym.done && cmp[0]; // RULE10
   // compare hits only reach the trigger in the two pattern modes
   wire fire =
      (mode_reg == ust_pkg::M_START && sym.st_edge) || // RULE2
      (mode_reg == ust_pkg::M_FSTART && fs) ||
      (mode_reg == ust_pkg::M_FERR && sym.ferr) || // RULE4
      (mode_reg == ust_pkg::M_SYM && sym.done && pos_reg == off_reg) || // RULE6
      (mode_reg == ust_pkg::M_BRK && sym.brk) || // RULE7
      (mode_reg == ust_pkg::M_PERR && sym.perr) ||
      (mode_reg == ust_pkg::M_PAT && f_pat) || // RULE16
      (mode_reg == ust_pkg::M_ANY && f_any);

   for (genvar i = 0; i < 4; i++) begin : g_cmp
      ust_symcmp #(.W(8)) u_cmp (
         .val(pval_reg[8*i +: 8]),
         .care(pmask_reg[8*i +: 8]),
         .data(sym.data[7:0]),
         .hit(cmp[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_reg <= ust_pkg::M_START;
         src_tx_reg <= 1'b0;
         par_reg <= ust_pkg::PAR_NONE;
         stop_reg <= 2'h0;
         dsize_reg <= ust_pkg::DSIZE_RST;
         bit_cyc_reg <= ust_pkg::BIT_CYC_DEF;
         idle_cyc_reg <= ust_pkg::IDLE_CYC_DEF;
         off_reg <= '0;
         cnt_m1_reg <= 2'h0;
         pval_reg <= 32'h0;
         pmask_reg <= 32'h0;
      end else if (wr) begin
         if (hit_ctrl) begin
            mode_reg <= pwdata[ust_pkg::F_MODE +: 3];
            src_tx_reg <= pwdata[ust_pkg::F_SRC];
            par_reg <= pwdata[ust_pkg::F_PAR +: 2];
            stop_reg <= pwdata[ust_pkg::F_STOP +: 2];
            dsize_reg <= dsize_fix;
         end
         if (hit_baud) bit_cyc_reg <= (pwdata[15:0] < 16'h0002) ? 16'h0002 : pwdata[15:0];
         if (hit_idle) idle_cyc_reg <= pwdata[23:0];
         if (hit_pcfg) off_reg <= off_w; // RULE12
         if (hit_pcfg) cnt_m1_reg <= cnt_fix;
         if (hit_pval) pval_reg <= pwdata;
         if (hit_pmask) pmask_reg <= pwdata;
         if (pat_wr && hi_sym > cnt_m1_reg) cnt_m1_reg <= hi_sym; // RULE14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // line select, symbol position and pattern chain
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         line_reg <= 1'b1;
         pos_reg <= '0;
         seq_reg <= 1'b0;
      end else begin
         line_reg <= src_tx_reg ? line_tx : line_rx; // RULE1
         if (fs) begin
            pos_reg <= '0; // RULE18
            seq_reg <= 1'b0;
         end else if (sym.done) begin
            if (pos_reg != '1) pos_reg <= pos_reg + OFF_W'(1);
            if (in_win) seq_reg <= chain_ok;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // trigger output and frame record
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trig_reg <= 1'b0;
         trig_cnt_reg <= 16'h0;
         ts_reg <= 32'h0;
         trig_time_reg <= 32'h0;
      end else begin
         trig_reg <= fire;
         ts_reg <= ts_reg + 32'h1;
         if (fire) trig_cnt_reg <= trig_cnt_reg + 16'h1;
         if (fire) trig_time_reg <= ts_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fs_time_reg <= 32'h0;
         rdata_reg <= 9'h0;
         words_reg <= '0;
         rstate_reg <= 3'h0;
      end else if (fs) begin
         fs_time_reg <= ts_reg; // RULE17
         words_reg <= '0;
         rstate_reg <= 3'h0;
      end else if (sym.done) begin
         rdata_reg <= sym.data;
         if (words_reg != '1) words_reg <= words_reg + OFF_W'(1);
         rstate_reg <= rstate_reg | {sym.brk, sym.perr, sym.ferr};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb answer: one access cycle, no wait states
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup && !addr_ok;
         if (setup) prdata_reg <= rd_mux;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign trig_out = trig_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_start_bit;
      (mode_reg == ust_pkg::M_START && sym.st_edge) |=> trig_out;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit missed"); // RULE2
   property p_fstart_gap;
      (mode_reg == ust_pkg::M_FSTART && sym.st_edge && !sym.idle_ok) |=> !trig_out;
   endproperty
   a_fstart_gap: assert property (p_fstart_gap) else $error("frame start without idle gap"); // RULE3
   property p_ferr;
      (mode_reg == ust_pkg::M_FERR && sym.done && sym.ferr) |=>
         trig_out && trig_cnt_reg == $past(trig_cnt_reg) + 16'h1;
   endproperty
   a_ferr: assert property (p_ferr) else $error("frame error missed"); // RULE4
   property p_ferr_src;
      sym.ferr |=> rstate_reg[0];
   endproperty
   a_ferr_src: assert property (p_ferr_src) else $error("framing error not recorded"); // RULE5
   property p_symbol;
      (mode_reg == ust_pkg::M_SYM && sym.done && pos_reg == off_reg) |=> trig_out;
   endproperty
   a_symbol: assert property (p_symbol) else $error("symbol n missed"); // RULE6
   property p_break;
      (mode_reg == ust_pkg::M_BRK && sym.brk) |=> trig_out ##1 !trig_out;
   endproperty
   a_break: assert property (p_break) else $error("break missed"); // RULE7
   property p_parity;
      (mode_reg == ust_pkg::M_PERR && sym.perr) |=> trig_out;
   endproperty
   a_parity: assert property (p_parity) else $error("parity error missed"); // RULE8
   property p_outside;
      (mode_reg == ust_pkg::M_PAT && sym.done && !in_win) |=> !trig_out;
   endproperty
   a_outside: assert property (p_outside) else $error("pattern fired outside window"); // RULE11
   property p_any;
      (mode_reg == ust_pkg::M_ANY && sym.done && cmp[0]) |=> trig_out;
   endproperty
   a_any: assert property (p_any) else $error("any symbol missed"); // RULE10
   property p_raise;
      (wr && hit_pmask && (|pwdata[31:24])) |=> cnt_m1_reg == 2'h3;
   endproperty
   a_raise: assert property (p_raise) else $error("count not raised"); // RULE14
   property p_off;
      (wr && hit_pcfg) |=> off_reg == $past(off_w);
   endproperty
   a_off: assert property (p_off) else $error("offset not stored"); // RULE12
   property p_restart;
      fs |=> pos_reg == '0 && words_reg == '0 && rstate_reg == 3'h0 && fs_time_reg == $past(ts_reg);
   endproperty
   a_restart: assert property (p_restart) else $error("frame start not restarted"); // RULE18

   c_pat: cover property (mode_reg == ust_pkg::M_PAT && trig_out);
   c_brk: cover property (sym.brk ##[1:400] fs);
   c_err: cover property (pslverr && pready);
endmodule

/* File: dv/ust_uart_tx.sv */
// uart transmitter model driving the observed serial lines
module ust_uart_tx (
   input wire logic clk_sys,
   output logic line_tx,
   output logic line_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int bit_cyc = 4;
   int dsize = 8;
   int par = 0;
   int stop = 0;
   logic src = 1'b0;
   initial begin
      line_tx = 1'b1;
      line_rx = 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   // only the selected line moves, the other stays idle high
   task automatic drive(input logic v, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         if (src) line_tx <= v;
         else line_rx <= v;
      end
   endtask
   // bit 9 spoils the parity bit, bit 10 pulls the stop bit low
   task automatic sym(input logic [10:0] s);
      logic p;
      p = (par == 2);
      drive(1'b0, bit_cyc);
      for (int i = 0; i < dsize; i++) begin
         drive(s[i], bit_cyc);
         p = p ^ s[i];
      end
      if (par != 0) drive(p ^ s[9], bit_cyc);
      drive(~s[10], bit_cyc * (2 + stop) / 2);
      if (s[10]) drive(1'b1, bit_cyc);
   endtask
   task automatic gap(input int n);
      drive(1'b1, n);
   endtask
endmodule

/* File: dv/tb_uart_serial_trigger.sv */
// self-checking bench for the uart serial trigger
module tb_uart_serial_trigger;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, line_tx, line_rx, trig_out;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [10:0] sq[$];
   logic [10:0] v;
   int n_errors = 0;
   int compares = 0;
   int n_trig = 0;
   int base = 0;
   int seed = 32'h7a6bbc37;
   ust_trigger i_ust_trigger (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_tx(line_tx), .line_rx(line_rx), .trig_out(trig_out));
   ust_uart_tx i_tx (.clk_sys(clk_sys), .line_tx(line_tx), .line_rx(line_rx));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (trig_out === 1'b1) n_trig <= n_trig + 1;
   end
   ////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected register value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_trig(input int exp);
      compares++;
      if (n_trig - base != exp) begin
         n_errors++;
         $display("unexpected trigger count at %0t: got %h expected %h", $time, n_trig - base, exp);
      end
      base = n_trig;
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("unexpected apb wait at %0t: pready %h expected %h", $time, pready, 1'b1);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
      chk_reg(r, exp);
      chk_reg({31'h0, e}, {31'h0, experr});
   endtask
   task automatic cfg(input logic [2:0] m, input logic s, input int p, input int st, input int ds);
      wr(ust_pkg::A_CTRL, (32'(m) << ust_pkg::F_MODE) | (32'(s) << ust_pkg::F_SRC) | (32'(p) << ust_pkg::F_PAR)
         | (32'(st) << ust_pkg::F_STOP) | (32'(ds) << ust_pkg::F_DSIZE));
      i_tx.src = s;
      i_tx.par = p;
      i_tx.stop = st;
      i_tx.dsize = ds;
   endtask
   task automatic frm(input int g);
      foreach (sq[i]) i_tx.sym(sq[i]);
      i_tx.gap(g);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(ust_pkg::A_CTRL, 32'h00000800, 1'b0);
      rd(ust_pkg::A_BAUD, 32'h0000015b, 1'b0);
      rd(ust_pkg::A_IDLE, 32'h00000d80, 1'b0);
      rd(ust_pkg::A_PCFG, 32'h00010000, 1'b0);
      rd(ust_pkg::A_PMASK, 32'h0, 1'b0);
      rd(8'h28, 32'h0, 1'b1);
      wr(ust_pkg::A_BAUD, 32'h4);
      wr(ust_pkg::A_IDLE, 32'h14);
      cfg(ust_pkg::M_START, 1'b0, 0, 0, 8);
      sq = '{11'h055, 11'h0aa, 11'h0ff};
      frm(40);
      chk_trig(3);
      i_tx.src = 1'b1;
      frm(40);
      chk_trig(0);
      cfg(ust_pkg::M_START, 1'b1, 0, 0, 8);
      frm(40);
      chk_trig(3);
      cfg(ust_pkg::M_FSTART, 1'b0, 0, 0, 8);
      frm(8);
      frm(40);
      chk_trig(1);
      frm(40);
      chk_trig(1);
      cfg(ust_pkg::M_FERR, 1'b0, 0, 0, 8);
      sq = '{11'h031, 11'h412, 11'h077};
      frm(40);
      chk_trig(1);
      rd(ust_pkg::A_RDATA, 32'h00030077, 1'b0);
      rd(ust_pkg::A_RSTATE, 32'h1, 1'b0);
      for (int p = 1; p < 3; p++) begin
         cfg(ust_pkg::M_PERR, 1'b0, p, 0, 8);
         sq = '{11'h0a5, 11'h2a5, 11'h03c};
         frm(40);
         chk_trig(1);
      end
      cfg(ust_pkg::M_BRK, 1'b0, 0, 0, 8);
      sq = '{11'h011, 11'h412, 11'h400};
      frm(40);
      chk_trig(1);
      cfg(ust_pkg::M_SYM, 1'b0, 0, 0, 8);
      wr(ust_pkg::A_PCFG, 32'h00010002);
      sq = '{11'h001, 11'h002, 11'h003, 11'h004};
      frm(40);
      frm(40);
      chk_trig(2);
      sq = '{11'h001, 11'h002};
      frm(40);
      chk_trig(0);
      wr(ust_pkg::A_PCFG, 32'h00000fff);
      rd(ust_pkg::A_PCFG, 32'h00010fff, 1'b0);
      wr(ust_pkg::A_PCFG, 32'h00070000);
      rd(ust_pkg::A_PCFG, 32'h00040000, 1'b0);
      wr(ust_pkg::A_PCFG, 32'h00010001);
      wr(ust_pkg::A_PMASK, 32'h0000ffff);
      rd(ust_pkg::A_PCFG, 32'h00020001, 1'b0);
      wr(ust_pkg::A_PVAL, 32'h00005a3c);
      cfg(ust_pkg::M_PAT, 1'b0, 0, 0, 8);
      sq = '{11'h011, 11'h03c, 11'h05a, 11'h099};
      frm(40);
      chk_trig(1);
      sq = '{11'h03c, 11'h05a, 11'h099};
      frm(40);
      chk_trig(0);
      wr(ust_pkg::A_PMASK, 32'h00000fff);
      sq = '{11'h011, 11'h03c, 11'h0fa};
      frm(40);
      chk_trig(1);
      wr(ust_pkg::A_PVAL, 32'h000000c3);
      wr(ust_pkg::A_PMASK, 32'h000000ff);
      cfg(ust_pkg::M_ANY, 1'b0, 0, 0, 8);
      sq = '{11'h011, 11'h022, 11'h0c3, 11'h044};
      frm(40);
      chk_trig(1);
      cfg(ust_pkg::M_SYM, 1'b0, 0, 0, 8);
      sq = '{11'h011, 11'h022};
      frm(40);
      chk_trig(1);
      for (int ds = 5; ds < 10; ds++) begin
         cfg(ust_pkg::M_START, 1'b0, 0, ds % 3, ds);
         v = 11'($random(seed)) & 11'((1 << ds) - 1);
         sq = '{v};
         frm(40);
         chk_trig(1);
         rd(ust_pkg::A_RDATA, {16'h0001, 7'h0, v[8:0]}, 1'b0);
      end
      rd(ust_pkg::A_STAT, 32'h00010017, 1'b0);
      rd(ust_pkg::A_RTIME, 32'h0, 1'b0);
      end_of_test();
   end
   initial begin
      #2_000_000;
      n_errors++;
      end_of_test();
   end
endmodule
